// >>> hdl/drs_eeprom_loader.sv
`timescale 1ns/1ps
`default_nettype none
module drs_eeprom_loader #(
  parameter logic [7:0] VERSION_CODE = 8'h3C // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] hall_code,
  input wire logic ee_rd_ack,
  input wire logic [7:0] ee_rd_data,
  output logic ee_rd_req,
  output logic [7:0] ee_addr,
  output logic wr_en,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic enc_en,
  output logic [15:0] enc_val,
  output logic done,
  output logic version_ok
);
  drs_pkg::drs_ld_state_t state_q;
  logic [7:0] lo_q;

  function automatic logic [7:0] hall_addr(input logic [2:0] code);
    hall_addr = drs_pkg::EE_HALL_BASE + {4'h0, code - 3'h1, 1'b0};
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= drs_pkg::DRS_LD_VER_RQ;
      ee_rd_req <= 1'b0;
      ee_addr <= 8'h00;
      wr_en <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      enc_en <= 1'b0;
      enc_val <= 16'h0000;
      lo_q <= 8'h00;
      done <= 1'b0;
      version_ok <= 1'b0;
    end else begin
      ee_rd_req <= 1'b0;
      wr_en <= 1'b0;
      enc_en <= 1'b0;
      case (state_q)
        drs_pkg::DRS_LD_VER_RQ: begin
          ee_addr <= drs_pkg::EE_VERSION_ADDR; // RULE14
          ee_rd_req <= 1'b1;
          state_q <= drs_pkg::DRS_LD_VER_WT;
        end
        drs_pkg::DRS_LD_VER_WT: begin
          if (ee_rd_ack) begin
            if (ee_rd_data == VERSION_CODE) begin // RULE14
              version_ok <= 1'b1;
              ee_addr <= 8'h00;
              state_q <= drs_pkg::DRS_LD_BLK_RQ;
            end else begin
              state_q <= drs_pkg::DRS_LD_DONE; // RULE23
            end
          end
        end
        drs_pkg::DRS_LD_BLK_RQ: begin
          ee_rd_req <= 1'b1;
          state_q <= drs_pkg::DRS_LD_BLK_WT;
        end
        drs_pkg::DRS_LD_BLK_WT: begin
          if (ee_rd_ack) begin
            wr_en <= 1'b1; // RULE15
            wr_addr <= ee_addr[6:0];
            wr_data <= ee_rd_data;
            if (ee_addr == drs_pkg::EE_BLOCK_LAST) begin
              if (hall_code != 3'h0 && hall_code != 3'h7) begin // RULE16
                ee_addr <= hall_addr(hall_code);
                state_q <= drs_pkg::DRS_LD_HLO_RQ;
              end else begin
                state_q <= drs_pkg::DRS_LD_DONE;
              end
            end else begin
              ee_addr <= ee_addr + 8'h01;
              state_q <= drs_pkg::DRS_LD_BLK_RQ;
            end
          end
        end
        drs_pkg::DRS_LD_HLO_RQ: begin
          ee_rd_req <= 1'b1;
          state_q <= drs_pkg::DRS_LD_HLO_WT;
        end
        drs_pkg::DRS_LD_HLO_WT: begin
          if (ee_rd_ack) begin
            lo_q <= ee_rd_data;
            ee_addr <= ee_addr + 8'h01;
            state_q <= drs_pkg::DRS_LD_HHI_RQ;
          end
        end
        drs_pkg::DRS_LD_HHI_RQ: begin
          ee_rd_req <= 1'b1;
          state_q <= drs_pkg::DRS_LD_HHI_WT;
        end
        drs_pkg::DRS_LD_HHI_WT: begin
          if (ee_rd_ack) begin
            enc_val <= {ee_rd_data, lo_q}; // RULE16
            enc_en <= 1'b1;
            state_q <= drs_pkg::DRS_LD_DONE;
          end
        end
        drs_pkg::DRS_LD_DONE: begin
          done <= 1'b1;
        end
        default: begin
          state_q <= drs_pkg::DRS_LD_DONE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdl/drs_offset_averager.sv
`timescale 1ns/1ps
`default_nettype none
module drs_offset_averager (
  input wire logic clk,
  input wire logic rst,
  input wire logic active,
  input wire logic sample_valid,
  input wire logic [15:0] raw_v,
  input wire logic [15:0] raw_w,
  output logic [15:0] offset_v,
  output logic [15:0] offset_w,
  output logic pass_done
);
  logic [11:0] cnt_q;
  logic [27:0] sum_v_q;
  logic [27:0] sum_w_q;
  logic [27:0] tot_v;
  logic [27:0] tot_w;

  function automatic logic [27:0] acc(input logic [27:0] sum, input logic [15:0] smp);
    acc = sum + {{12{smp[15]}}, smp};
  endfunction

  assign tot_v = acc(sum_v_q, raw_v);
  assign tot_w = acc(sum_w_q, raw_w);

  // Average of a full pass of consecutive samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 12'h000;
      sum_v_q <= 28'h0000000;
      sum_w_q <= 28'h0000000;
      offset_v <= 16'h0000;
      offset_w <= 16'h0000;
      pass_done <= 1'b0;
    end else begin
      pass_done <= 1'b0;
      if (!active) begin
        cnt_q <= 12'h000;
        sum_v_q <= 28'h0000000;
        sum_w_q <= 28'h0000000;
      end else if (sample_valid) begin
        if (cnt_q == drs_pkg::AVG_LAST) begin // RULE2 RULE3
          offset_v <= tot_v[27:drs_pkg::AVG_SHIFT];
          offset_w <= tot_w[27:drs_pkg::AVG_SHIFT];
          pass_done <= 1'b1;
          cnt_q <= 12'h000;
          sum_v_q <= 28'h0000000;
          sum_w_q <= 28'h0000000;
        end else begin
          cnt_q <= cnt_q + 12'h001;
          sum_v_q <= tot_v;
          sum_w_q <= tot_w;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/drs_pkg.sv
package drs_pkg;
  // Clocking and sample timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SAMPLE_HZ = 120000;
  localparam int unsigned SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned CAL_HOLD_MS = 100;
  localparam int unsigned PIN_PULSE_NS = 100;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int unsigned PIN_PULSE_CYC = (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Offset averaging
  localparam int unsigned AVG_SAMPLES = 4096;
  localparam int unsigned AVG_SHIFT = 12;
  localparam logic [11:0] AVG_LAST = 12'hFFF;

  // EEPROM image
  localparam logic [7:0] EE_VERSION_ADDR = 8'h5D;
  localparam logic [7:0] EE_BLOCK_LAST = 8'h7F;
  localparam logic [7:0] EE_HALL_BASE = 8'h72;
  localparam logic [7:0] EE_HALL_END = 8'h7D;

  // Host write byte registers, 0x00 to 0x7F
  localparam logic [6:0] HW_CTRL = 7'h00;
  localparam logic [6:0] HW_SYSCFG = 7'h01;
  localparam logic [6:0] HW_SPEED_LO = 7'h02;
  localparam logic [6:0] HW_SPEED_HI = 7'h03;
  localparam logic [6:0] HW_OFFV_LO = 7'h04;
  localparam logic [6:0] HW_OFFV_HI = 7'h05;
  localparam logic [6:0] HW_OFFW_LO = 7'h06;
  localparam logic [6:0] HW_OFFW_HI = 7'h07;
  localparam logic [6:0] HW_ENC_LO = 7'h08;
  localparam logic [6:0] HW_ENC_HI = 7'h09;
  localparam int unsigned HW_BYTES = 128;
  localparam logic [7:0] HW_RESET = 8'h00;

  // Control byte and system configuration byte fields
  localparam int unsigned CTRL_MOD_EN = 0;
  localparam int unsigned CTRL_VC_EN = 1;
  localparam int unsigned CTRL_OFFS_SEL = 2;
  localparam int unsigned CTRL_DCCOMP = 3;
  localparam int unsigned CTRL_FLT_CLR = 4;
  localparam int unsigned SYSCFG_PIN_CTRL = 0;

  // Read registers
  localparam logic [7:0] RD_STATUS = 8'h80;
  localparam logic [7:0] RD_FAULTS = 8'h81;
  localparam logic [7:0] RD_CALC_V = 8'h82;
  localparam logic [7:0] RD_CALC_W = 8'h83;
  localparam logic [7:0] RD_RAW_V = 8'h84;
  localparam logic [7:0] RD_RAW_W = 8'h85;

  typedef enum logic [3:0] {
    DRS_LD_VER_RQ = 4'h0,
    DRS_LD_VER_WT = 4'h1,
    DRS_LD_BLK_RQ = 4'h3,
    DRS_LD_BLK_WT = 4'h2,
    DRS_LD_HLO_RQ = 4'h6,
    DRS_LD_HLO_WT = 4'h7,
    DRS_LD_HHI_RQ = 4'h5,
    DRS_LD_HHI_WT = 4'h4,
    DRS_LD_DONE = 4'hC
  } drs_ld_state_t;
endpackage

// >>> hdl/drs_run_control.sv
// Notes on behaviour
// RULE1: PWM on, control off gives zero duty
// RULE2: Average 4096 samples into calculated offsets
// RULE3: Samples at 120 kHz, pass about 34 ms
// RULE4: Select bit one uses calculated offsets
// RULE5: Select bit zero uses host offsets
// RULE6: Raw feedback readable, host offsets writable
// RULE7: Host start sequence with 100 ms calibration
// RULE8: Coasting stop clears both enables
// RULE9: Controlled stop ramps speed then clears
// RULE10: Stop pin disables PWM regardless
// RULE11: Fault clears enables, flags, lights red
// RULE12: PWM off until cleared and re-enabled
// RULE13: Clear bit one clears, zero re-arms
// RULE14: Check EEPROM version byte at power-up
// RULE15: Load 128 bytes into write registers
// RULE16: Hall code picks stored encoder count
// RULE17: Loaded pin-control field enables pin control
// RULE18: Calibration pin forces calibration condition
// RULE19: Start and stop pins, stop wins
// RULE20: Pins pulse at least 100 ns
// RULE21: Pin mode fault output and clear pin
// RULE22: Subtract selected offset from raw sample
// RULE23: Version mismatch keeps reset defaults
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module drs_run_control #(
  parameter logic [7:0] VERSION_CODE = 8'h3C // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic [15:0] raw_current_phase_v,
  input wire logic [15:0] raw_current_phase_w,
  input wire logic sample_valid,
  input wire logic [7:0] fault_detect,
  input wire logic stop_pin,
  input wire logic start_pin,
  input wire logic calibration_request_in,
  input wire logic fault_clear_in,
  input wire logic [2:0] hall_pin,
  output logic ee_rd_req,
  output logic [7:0] ee_addr,
  input wire logic ee_rd_ack,
  input wire logic [7:0] ee_rd_data,
  output logic modulator_run,
  output logic zero_duty_cal,
  output logic vector_control_run,
  output logic bus_voltage_comp_enable,
  output logic [15:0] velocity_setpoint,
  output logic [15:0] corr_current_v,
  output logic [15:0] corr_current_w,
  output logic corr_valid,
  output logic [15:0] encoder_count_load,
  output logic encoder_count_load_stb,
  output logic fault_out,
  output logic red_led
);
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  logic stop_s;
  logic start_s;
  logic cal_s;
  logic fclr_s;
  logic [2:0] hall_s;

  logic [7:0] hw_q [0:drs_pkg::HW_BYTES-1];
  logic [7:0] fault_flags_q;
  logic [15:0] raw_v_q;
  logic [15:0] raw_w_q;
  logic [15:0] bus_rdata_q;

  logic ld_we;
  logic [6:0] ld_addr;
  logic [7:0] ld_data;
  logic ld_enc_en;
  logic [15:0] ld_enc_val;
  logic ld_done;
  logic ld_ver_ok;

  logic [15:0] calc_offset_phase_v;
  logic [15:0] calc_offset_phase_w;
  logic avg_done;

  logic [7:0] ctrl;
  logic pin_control_select;
  logic offset_source_select;
  logic fault_clear_bit;
  logic [15:0] host_offset_phase_v;
  logic [15:0] host_offset_phase_w;
  logic pin_mode;
  logic cal_force;
  logic mod_req;
  logic run_ok;
  logic [7:0] fault_new;
  logic fault_any_new;
  logic flags_clear;

  function automatic logic [15:0] sub_offset(input logic [15:0] raw, input logic [15:0] offs);
    sub_offset = raw - offs;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 7'h00;
      pin_sync_q <= 7'h00;
    end else begin
      pin_meta_q <= {stop_pin, start_pin, calibration_request_in, fault_clear_in, hall_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign stop_s = pin_sync_q[6];
  assign start_s = pin_sync_q[5];
  assign cal_s = pin_sync_q[4];
  assign fclr_s = pin_sync_q[3];
  assign hall_s = pin_sync_q[2:0];

  drs_eeprom_loader #(
    .VERSION_CODE(VERSION_CODE)
  ) u_loader (
    .clk(clk),
    .rst(rst),
    .hall_code(hall_s),
    .ee_rd_ack(ee_rd_ack),
    .ee_rd_data(ee_rd_data),
    .ee_rd_req(ee_rd_req),
    .ee_addr(ee_addr),
    .wr_en(ld_we),
    .wr_addr(ld_addr),
    .wr_data(ld_data),
    .enc_en(ld_enc_en),
    .enc_val(ld_enc_val),
    .done(ld_done),
    .version_ok(ld_ver_ok)
  );

  // Decoded control fields
  assign ctrl = hw_q[drs_pkg::HW_CTRL];
  assign offset_source_select = ctrl[drs_pkg::CTRL_OFFS_SEL];
  assign fault_clear_bit = ctrl[drs_pkg::CTRL_FLT_CLR];
  assign pin_control_select = hw_q[drs_pkg::HW_SYSCFG][drs_pkg::SYSCFG_PIN_CTRL];
  assign host_offset_phase_v = {hw_q[drs_pkg::HW_OFFV_HI], hw_q[drs_pkg::HW_OFFV_LO]};
  assign host_offset_phase_w = {hw_q[drs_pkg::HW_OFFW_HI], hw_q[drs_pkg::HW_OFFW_LO]};
  assign pin_mode = pin_control_select & ld_done; // RULE17

  assign cal_force = pin_mode & cal_s; // RULE18
  assign mod_req = ctrl[drs_pkg::CTRL_MOD_EN] | cal_force;
  assign run_ok = ~stop_s & ~(|fault_flags_q); // RULE10 RULE12

  assign fault_new = fault_detect & {8{~fault_clear_bit}}; // RULE13
  assign fault_any_new = |fault_new;
  assign flags_clear = fault_clear_bit | (pin_mode & fclr_s); // RULE13 RULE21

  // Host write registers, loaded from EEPROM at power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < drs_pkg::HW_BYTES; i++) begin
        hw_q[i] <= drs_pkg::HW_RESET;
      end
    end else begin
      if (ld_we) begin
        hw_q[ld_addr] <= ld_data; // RULE15
      end else if (bus_wr && !bus_addr[7]) begin
        hw_q[bus_addr[6:0]] <= bus_wdata[7:0]; // RULE6
      end
      if (ld_enc_en) begin
        hw_q[drs_pkg::HW_ENC_LO] <= ld_enc_val[7:0]; // RULE16
        hw_q[drs_pkg::HW_ENC_HI] <= ld_enc_val[15:8];
      end
      if (pin_mode) begin
        if (stop_s) begin // RULE19
          hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_MOD_EN] <= 1'b0;
          hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_VC_EN] <= 1'b0;
        end else if (start_s) begin
          hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_MOD_EN] <= 1'b1;
          hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_VC_EN] <= 1'b1;
        end
      end
      if (fault_any_new) begin
        hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_MOD_EN] <= 1'b0; // RULE11
        hw_q[drs_pkg::HW_CTRL][drs_pkg::CTRL_VC_EN] <= 1'b0;
      end
    end
  end

  // Fault latch, a new fault beats a pin clear, the clear bit masks new faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_flags_q <= 8'h00;
    end else begin
      fault_flags_q <= (fault_flags_q & {8{~flags_clear}}) | fault_new; // RULE11 RULE13
    end
  end

  // Fault indicators
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_out <= 1'b0;
      red_led <= 1'b0;
    end else begin
      fault_out <= |fault_flags_q | fault_any_new; // RULE21
      red_led <= |fault_flags_q | fault_any_new; // RULE11
    end
  end

  // Run state of the modulator and vector control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modulator_run <= 1'b0;
      vector_control_run <= 1'b0;
      zero_duty_cal <= 1'b0;
    end else begin
      modulator_run <= run_ok & ~fault_any_new & mod_req; // RULE10 RULE11
      vector_control_run <= run_ok & ~fault_any_new & ctrl[drs_pkg::CTRL_VC_EN]
        & ~cal_force & ctrl[drs_pkg::CTRL_MOD_EN];
      zero_duty_cal <= run_ok & ~fault_any_new & mod_req
        & (~ctrl[drs_pkg::CTRL_VC_EN] | cal_force); // RULE1 RULE18
    end
  end

  // Configuration outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_voltage_comp_enable <= 1'b0;
      velocity_setpoint <= 16'h0000;
    end else begin
      bus_voltage_comp_enable <= ctrl[drs_pkg::CTRL_DCCOMP];
      velocity_setpoint <= {hw_q[drs_pkg::HW_SPEED_HI], hw_q[drs_pkg::HW_SPEED_LO]};
    end
  end

  // Encoder count load strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      encoder_count_load <= 16'h0000;
      encoder_count_load_stb <= 1'b0;
    end else begin
      encoder_count_load_stb <= 1'b0;
      if (ld_enc_en) begin
        encoder_count_load <= ld_enc_val; // RULE16
        encoder_count_load_stb <= 1'b1;
      end else if (bus_wr && bus_addr[6:0] == drs_pkg::HW_ENC_HI && !bus_addr[7]) begin
        encoder_count_load <= {bus_wdata[7:0], hw_q[drs_pkg::HW_ENC_LO]};
        encoder_count_load_stb <= 1'b1;
      end
    end
  end

  // Offset averaging while in the calibration condition
  drs_offset_averager u_avg (
    .clk(clk),
    .rst(rst),
    .active(zero_duty_cal),
    .sample_valid(sample_valid),
    .raw_v(raw_current_phase_v),
    .raw_w(raw_current_phase_w),
    .offset_v(calc_offset_phase_v),
    .offset_w(calc_offset_phase_w),
    .pass_done(avg_done)
  );

  // Raw capture and offset correction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_v_q <= 16'h0000;
      raw_w_q <= 16'h0000;
      corr_current_v <= 16'h0000;
      corr_current_w <= 16'h0000;
      corr_valid <= 1'b0;
    end else begin
      corr_valid <= sample_valid;
      if (sample_valid) begin
        raw_v_q <= raw_current_phase_v; // RULE6
        raw_w_q <= raw_current_phase_w;
        if (offset_source_select) begin // RULE4 RULE22
          corr_current_v <= sub_offset(raw_current_phase_v, calc_offset_phase_v);
          corr_current_w <= sub_offset(raw_current_phase_w, calc_offset_phase_w);
        end else begin // RULE5 RULE22
          corr_current_v <= sub_offset(raw_current_phase_v, host_offset_phase_v);
          corr_current_w <= sub_offset(raw_current_phase_w, host_offset_phase_w);
        end
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= 16'h0000;
    end else if (bus_rd) begin
      if (!bus_addr[7]) begin
        bus_rdata_q <= {8'h00, hw_q[bus_addr[6:0]]};
      end else begin
        case (bus_addr)
          drs_pkg::RD_STATUS: begin
            bus_rdata_q <= {10'h000, ld_ver_ok, ld_done, zero_duty_cal, avg_done,
              vector_control_run, modulator_run}; // RULE11
          end
          drs_pkg::RD_FAULTS: bus_rdata_q <= {8'h00, fault_flags_q};
          drs_pkg::RD_CALC_V: bus_rdata_q <= calc_offset_phase_v; // RULE2
          drs_pkg::RD_CALC_W: bus_rdata_q <= calc_offset_phase_w;
          drs_pkg::RD_RAW_V: bus_rdata_q <= raw_v_q; // RULE6
          drs_pkg::RD_RAW_W: bus_rdata_q <= raw_w_q;
          default: bus_rdata_q <= 16'h0000;
        endcase
      end
    end else begin
      bus_rdata_q <= 16'h0000;
    end
  end

  assign bus_rdata = bus_rdata_q;
endmodule
`default_nettype wire

// >>> test/drs_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module drs_eeprom_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ee_rd_req,
  input wire logic [7:0] ee_addr,
  output logic ee_rd_ack,
  output logic [7:0] ee_rd_data
);
  logic [7:0] mem [0:255];
  logic [7:0] addr_q;
  logic [1:0] wait_q;
  logic busy_q;
  // Odd addresses answer slowly, data toggles outside an ack
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      wait_q <= 2'h0;
      addr_q <= 8'h00;
      ee_rd_ack <= 1'b0;
      ee_rd_data <= 8'h00;
    end else begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req) begin
        busy_q <= 1'b1;
        addr_q <= ee_addr;
        wait_q <= ee_addr[0] ? 2'h3 : 2'h0;
      end else if (busy_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        ee_rd_ack <= 1'b1;
        ee_rd_data <= mem[addr_q];
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/drs_run_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module drs_run_control_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic sample_valid,
  input wire logic stop_pin,
  input wire logic ee_rd_req,
  input wire logic [7:0] ee_addr,
  input wire logic modulator_run,
  input wire logic zero_duty_cal,
  input wire logic vector_control_run,
  input wire logic corr_valid,
  input wire logic fault_out,
  input wire logic red_led,
  input wire logic encoder_count_load_stb
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_fault_run_off: assert property (fault_out |-> !modulator_run && !vector_control_run
    && !zero_duty_cal) else $error("run output high while fault latched");
  a_fault_red_led: assert property (fault_out |-> red_led)
    else $error("red indicator off during fault");
  a_stop_pin_kill: assert property (stop_pin [*3] |=> !modulator_run && !vector_control_run)
    else $error("stop pin did not disable drive");
  a_cal_no_vc: assert property (zero_duty_cal |-> !vector_control_run)
    else $error("vector control during zero duty");
  a_vc_needs_mod: assert property (vector_control_run |-> modulator_run)
    else $error("vector control without modulator");
  a_corr_timing: assert property (corr_valid == $past(sample_valid))
    else $error("corrected sample not one cycle after raw sample");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (bus_rd && bus_addr >= 8'h86 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ee_first: assert property ($fell(rst) |-> ##[1:2] (ee_rd_req && ee_addr == 8'h5D))
    else $error("version byte not read first");
  a_ee_req_pulse: assert property (ee_rd_req |=> !ee_rd_req)
    else $error("eeprom request longer than one cycle");

  c_cal: cover property (zero_duty_cal && modulator_run);
  c_fault: cover property ($rose(fault_out));
  c_enc: cover property (encoder_count_load_stb);
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] VER = 8'h5A; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] raw_v = 16'h0000;
  logic [15:0] raw_w = 16'h0000;
  logic sample_valid = 1'b0;
  logic [7:0] fault_detect = 8'h00;
  logic [3:0] pins_q = 4'h0;
  logic ee_rd_req, ee_rd_ack, modulator_run, zero_duty_cal, vector_control_run;
  logic bus_voltage_comp_enable, corr_valid, encoder_count_load_stb, fault_out, red_led;
  logic [7:0] ee_addr, ee_rd_data;
  logic [15:0] bus_rdata, velocity_setpoint, corr_current_v, corr_current_w, encoder_count_load;
  logic [31:0] seed = 32'hE0E1699C;
  logic [31:0] r;
  logic [15:0] d, ev, ew;
  int fails = 0;
  int checked = 0;
  int sv, sw;

  always #12.5 clk = ~clk;

  drs_run_control #(.VERSION_CODE(VER)) i_dut (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .raw_current_phase_v(raw_v),
    .raw_current_phase_w(raw_w), .sample_valid(sample_valid), .fault_detect(fault_detect),
    .stop_pin(pins_q[0]), .start_pin(pins_q[1]), .calibration_request_in(pins_q[2]),
    .fault_clear_in(pins_q[3]), .hall_pin(3'h3), .ee_rd_req(ee_rd_req), .ee_addr(ee_addr),
    .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .modulator_run(modulator_run),
    .zero_duty_cal(zero_duty_cal), .vector_control_run(vector_control_run),
    .bus_voltage_comp_enable(bus_voltage_comp_enable), .velocity_setpoint(velocity_setpoint),
    .corr_current_v(corr_current_v), .corr_current_w(corr_current_w), .corr_valid(corr_valid),
    .encoder_count_load(encoder_count_load), .encoder_count_load_stb(encoder_count_load_stb),
    .fault_out(fault_out), .red_led(red_led)
  );

  drs_eeprom_model i_ee (
    .clk(clk), .rst(rst), .ee_rd_req(ee_rd_req), .ee_addr(ee_addr),
    .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask

  task automatic samp();
    r = rnd();
    raw_v <= r[15:0];
    raw_w <= r[31:16];
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Pins held 125 ns
  task automatic pins(input logic [3:0] m);
    pins_q <= m;
    cyc(5);
  endtask

  task automatic results();
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    cyc(60000);
    fails++;
    results();
  end

  initial begin
    for (int a = 0; a < 256; a++) begin
      r = rnd();
      i_ee.mem[a] = r[7:0];
    end
    i_ee.mem[0] = 8'h00;
    i_ee.mem[1] = 8'h00;
    i_ee.mem[8'h5D] = VER;
    cyc(6);
    rst <= 1'b0;
    for (int i = 0; i < 3000 && encoder_count_load_stb !== 1'b1; i++) cyc(1);
    chk("enc_load", {i_ee.mem[8'h77], i_ee.mem[8'h76]}, encoder_count_load);
    cyc(2);
    chk("speed", {i_ee.mem[3], i_ee.mem[2]}, velocity_setpoint);
    rd(8'h80);
    chk("status", 16'h0030, d & 16'h0030);
    wr(8'h00, 16'h0001);
    cyc(3);
    chk("cal", 16'h0006, {13'h0, zero_duty_cal, modulator_run, vector_control_run});
    sv = 0;
    sw = 0;
    repeat (4096) begin
      samp();
      sv += int'($signed(r[15:0]));
      sw += int'($signed(r[31:16]));
    end
    ev = 16'(sv >>> 12);
    ew = 16'(sw >>> 12);
    cyc(2);
    rd(8'h82);
    chk("calc_v", ev, d);
    rd(8'h83);
    chk("calc_w", ew, d);
    rd(8'h84);
    chk("raw_v", r[15:0], d);
    wr(8'h04, 16'h0034);
    wr(8'h05, 16'h0012);
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, (s != 0) ? 16'h0007 : 16'h0003);
      cyc(2);
      samp();
      chk("corr_valid", 16'h0001, {15'h0, corr_valid});
      chk("corr_v", r[15:0] - ((s != 0) ? ev : 16'h1234), corr_current_v);
    end
    fault_detect <= 8'h04;
    cyc(1);
    fault_detect <= 8'h00;
    cyc(2);
    chk("fault_led", 16'h0003, {14'h0, fault_out, red_led});
    chk("fault_run", 16'h0000, {14'h0, modulator_run, vector_control_run});
    rd(8'h81);
    chk("flags", 16'h0004, d);
    rd(8'h00);
    chk("ctrl", 16'h0004, d);
    wr(8'h00, 16'h0003);
    cyc(3);
    chk("latched", 16'h0000, {15'h0, modulator_run});
    wr(8'h00, 16'h0010);
    wr(8'h00, 16'h0000);
    cyc(3);
    chk("cleared", 16'h0000, {15'h0, fault_out});
    wr(8'h00, 16'h0003);
    cyc(3);
    chk("rerun", 16'h0003, {14'h0, modulator_run, vector_control_run});
    pins(4'b0001);
    chk("stop_pin", 16'h0000, {14'h0, modulator_run, vector_control_run});
    pins(4'b0000);
    wr(8'h02, 16'h0000);
    wr(8'h03, 16'h0000);
    cyc(2);
    chk("speed_zero", 16'h0000, velocity_setpoint);
    wr(8'h00, 16'h0000);
    cyc(2);
    chk("coast", 16'h0000, {14'h0, modulator_run, vector_control_run});
    wr(8'h01, 16'h0001);
    pins(4'b0010);
    pins(4'b0000);
    chk("pin_start", 16'h0003, {14'h0, modulator_run, vector_control_run});
    pins(4'b0011);
    chk("pin_both", 16'h0000, {14'h0, modulator_run, vector_control_run});
    pins(4'b0100);
    chk("pin_cal", 16'h0001, {15'h0, zero_duty_cal});
    pins(4'b0000);
    fault_detect <= 8'h01;
    cyc(1);
    fault_detect <= 8'h00;
    cyc(2);
    chk("pin_fault", 16'h0001, {15'h0, fault_out});
    pins(4'b1000);
    pins(4'b0000);
    chk("pin_clear", 16'h0000, {15'h0, fault_out});
    rd(8'h90);
    chk("unmapped", 16'h0000, d);
    wr(8'h82, 16'hFFFF);
    rd(8'h82);
    chk("calc_ro", ev, d);
    i_ee.mem[8'h5D] = ~VER;
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    cyc(400);
    chk("no_load", 16'h0000, velocity_setpoint);
    rd(8'h80);
    chk("ver_bad", 16'h0000, d & 16'h0020);
    results();
  end
endmodule

bind drs_run_control drs_run_control_asserts i_chk (
  .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .sample_valid(sample_valid), .stop_pin(stop_pin), .ee_rd_req(ee_rd_req), .ee_addr(ee_addr),
  .modulator_run(modulator_run), .zero_duty_cal(zero_duty_cal),
  .vector_control_run(vector_control_run), .corr_valid(corr_valid), .fault_out(fault_out),
  .red_led(red_led), .encoder_count_load_stb(encoder_count_load_stb)
);
`default_nettype wire
